// ===== rtl/pmcc_cfg.svh
// Constants of the power-mode and clock control block.
// Assumes it is included once per compilation unit by bare name.
`ifndef PMCC_CFG_SVH
`define PMCC_CFG_SVH
`define PWR_CTRL_ADDR     8'h87
`define CLK_CTRL_ADDR     8'hF9
`define PWR_CTRL_RESET    8'h00
`define CLK_CTRL_RESET    8'h10
`define PWR_LIGHT_BIT     0
`define PWR_DEEP_BIT      1
`define PWR_TX_SEL_BIT    2
`define PWR_RX_SEL_BIT    3
`define PWR_COLD_BIT      4
`define PWR_RSVD_BIT      5
`define PWR_DBL1_BIT      6
`define PWR_DBL0_BIT      7
`define CLK_DIV_LSB       0
`define CLK_DIV_MSB       2
`define CLK_AUTO_BIT      3
`define CLK_DBG_BIT       4
`define RESTART_MCYC      3
`define OSC_PER_MCYC      12
`define BUS_IDLE_BYTE     8'hFF
`endif

// ===== rtl/pmcc_pkg.sv
// Types shared by the power-mode and clock control block.
// Assumes pmcc_cfg.svh is on the include path.
package pmcc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic       ale;
    logic       fetch_strobe_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] ad;
    logic       ad_oe;
    logic [7:0] addr_hi;
  } ext_bus_s;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_LIGHT = 3'b010,
    ST_DEEP  = 3'b100
  } pwr_state_e;
endpackage

// ===== rtl/power_mode_clock_control.sv
// Power-mode and clock-enable controller for the microcontroller module.
// Assumes the core SFR bus, interrupt request and bus signals share sys_clk,
// and that rst_b is the supervisor reset (pin, brownout, debug, power-on).
//
// What this block does
// - Light sleep stops the core and watchdog clocks; unit clock keeps running.
// - Writing one to bit 0 of power control enters light sleep.
// - Enabled interrupt in light sleep clears the bit and resumes core.
// - Supervisor reset ends light sleep; core restarts after three machine cycles.
// - Interrupts, timers, converter, serial ports, counters stay active in light sleep.
// - Watchdog stops in light sleep; other reset sources still act.
// - Light sleep preserves all core state and memories.
// - General-purpose port outputs hold their levels in both sleep modes.
// - Writing one to bit 1 gates core and unit clocks.
// - Deep sleep stops the oscillator and all clocks, keeping state.
// - Deep sleep ends only on supervisor reset; no watchdog reset.
// - Sleeping bus drives strobe low, other strobes high, FFh on bytes.
// - Core divider spans 1/1 to 1/2048, touching only core and watchdog.
// - With auto restore set, any interrupt outside deep sleep forces divider select to 000.
// - Cold-start bit 4 set by power-on reset or a firmware write; firmware clears it.
// - Bits 7 and 6 select rate doubling for the two UARTs.
// - Divider codes map to 1,2,4,8,16,32,1024,2048; effective at once.
// - Clock control register resets to 10h.
`timescale 1ns/1ps
`include "pmcc_cfg.svh"

module power_mode_clock_control #(
  parameter int OSC_PER_MCYC = `OSC_PER_MCYC
) (
  input  wire logic               sys_clk,              // Oscillator clock
  input  wire logic               rst_b,                // Supervisor reset, low
  input  wire logic               cold_reset,           // Reset cause is power-on
  input  wire pmcc_pkg::sfr_req_s sfr_req,              // Core SFR access
  input  wire logic               irq_req,              // Any enabled interrupt
  input  wire pmcc_pkg::ext_bus_s core_bus,             // Bus from the core
  output logic [7:0]              sfr_rdata,            // Read data, next cycle
  output logic                    sfr_hit,              // Read address matched
  output logic                    core_clk_en,          // Core clock enable
  output logic                    wdt_clk_en,           // Watchdog clock enable
  output logic                    unit_clk_en,          // Peripheral clock enable
  output logic                    osc_stop,             // Stop the oscillator
  output logic                    port_hold,            // Freeze port outputs
  output logic                    dbg_cmp_en,           // Breakpoint comparators on
  output logic                    uart0_rate_doubler,   // UART0 doubling
  output logic                    uart1_rate_doubler,   // UART1 doubling
  output logic                    uart1_receive_timer_select,  // UART1 rx select
  output logic                    uart1_transmit_timer_select, // UART1 tx select
  output pmcc_pkg::ext_bus_s      ext_bus               // Bus to pins
);
  import pmcc_pkg::*;

  localparam int RESTART_CLKS = `RESTART_MCYC * OSC_PER_MCYC;

  function automatic logic [11:0] div_ratio(input logic [2:0] sel);
    case (sel)
      3'h0:    div_ratio = 12'h001;
      3'h1:    div_ratio = 12'h002;
      3'h2:    div_ratio = 12'h004;
      3'h3:    div_ratio = 12'h008;
      3'h4:    div_ratio = 12'h010;
      3'h5:    div_ratio = 12'h020;
      3'h6:    div_ratio = 12'h400;
      default: div_ratio = 12'h800;
    endcase
  endfunction

  logic [7:0]  pwr_q;
  logic [4:0]  clk_q;
  pwr_state_e  state_q;
  logic [11:0] div_cnt_q;
  logic [7:0]  hold_cnt_q;
  logic        hold_q;
  logic [7:0]  rel_cnt_q;

  logic wr_pwr;
  logic wr_clk;
  logic div_tick;

  assign wr_pwr = sfr_req.wr && (sfr_req.addr == `PWR_CTRL_ADDR);
  assign wr_clk = sfr_req.wr && (sfr_req.addr == `CLK_CTRL_ADDR);
  assign div_tick = (div_cnt_q == div_ratio(clk_q[`CLK_DIV_MSB:`CLK_DIV_LSB]) - 12'h001);

  // Power control register; the interrupt wins over a same-cycle light-sleep write
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pwr_q <= `PWR_CTRL_RESET;
      pwr_q[`PWR_COLD_BIT] <= pwr_q[`PWR_COLD_BIT] | cold_reset;
    end else begin
      if (wr_pwr) begin
        pwr_q <= sfr_req.wdata;
        pwr_q[`PWR_RSVD_BIT] <= 1'b0;
      end
      if (irq_req && (state_q != ST_DEEP)) begin
        pwr_q[`PWR_LIGHT_BIT] <= 1'b0;
      end
    end
  end

  // Clock control register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clk_q <= 5'(`CLK_CTRL_RESET);
    end else begin
      if (wr_clk) begin
        clk_q <= sfr_req.wdata[4:0];
      end
      if (irq_req && clk_q[`CLK_AUTO_BIT] && (state_q != ST_DEEP)) begin
        clk_q[`CLK_DIV_MSB:`CLK_DIV_LSB] <= 3'h0;
      end
    end
  end

  // Mode sequencer; deep sleep leaves only through rst_b
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (wr_pwr && sfr_req.wdata[`PWR_DEEP_BIT]) begin
            state_q <= ST_DEEP;
          end else if (wr_pwr && sfr_req.wdata[`PWR_LIGHT_BIT] && !irq_req) begin
            state_q <= ST_LIGHT;
          end
        end
        ST_LIGHT: begin
          if (irq_req) begin
            state_q <= ST_RUN;
          end
        end
        ST_DEEP: begin
          state_q <= ST_DEEP;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Divider restarts on a select write so the new ratio applies at once
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      div_cnt_q <= 12'h000;
    end else if (wr_clk || (irq_req && clk_q[`CLK_AUTO_BIT])) begin
      div_cnt_q <= 12'h000;
    end else if (div_tick) begin
      div_cnt_q <= 12'h000;
    end else begin
      div_cnt_q <= div_cnt_q + 12'h001;
    end
  end

  // Core held for three machine cycles after each supervisor reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hold_cnt_q <= 8'h00;
      hold_q     <= 1'b1;
    end else if (hold_q) begin
      hold_cnt_q <= hold_cnt_q + 8'h01;
      if (hold_cnt_q == 8'(RESTART_CLKS - 1)) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Enables are whole-cycle flops; a gating cell latches them, no runt pulses
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      core_clk_en <= 1'b0;
      wdt_clk_en  <= 1'b0;
      unit_clk_en <= 1'b0;
      osc_stop    <= 1'b0;
      port_hold   <= 1'b0;
    end else begin
      core_clk_en <= (state_q == ST_RUN) && !hold_q && div_tick;
      wdt_clk_en  <= (state_q == ST_RUN) && !hold_q && div_tick;
      unit_clk_en <= (state_q != ST_DEEP);
      osc_stop    <= (state_q == ST_DEEP);
      port_hold   <= (state_q != ST_RUN);
    end
  end

  // External bus parks at fixed levels while asleep
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ext_bus <= '{ale: 1'b0, fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                   ad: `BUS_IDLE_BYTE, ad_oe: 1'b1, addr_hi: `BUS_IDLE_BYTE};
    end else if (state_q != ST_RUN) begin
      ext_bus <= '{ale: 1'b0, fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                   ad: `BUS_IDLE_BYTE, ad_oe: 1'b1, addr_hi: `BUS_IDLE_BYTE};
    end else begin
      ext_bus <= core_bus;
    end
  end

  // Register read port, one cycle behind the request
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else if (sfr_req.rd && (sfr_req.addr == `PWR_CTRL_ADDR)) begin
      sfr_rdata <= pwr_q;
      sfr_hit   <= 1'b1;
    end else if (sfr_req.rd && (sfr_req.addr == `CLK_CTRL_ADDR)) begin
      sfr_rdata <= {3'h0, clk_q};
      sfr_hit   <= 1'b1;
    end else begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end
  end

  // Control bits handed to neighbouring units
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dbg_cmp_en                  <= 1'b1;
      uart0_rate_doubler          <= 1'b0;
      uart1_rate_doubler          <= 1'b0;
      uart1_receive_timer_select  <= 1'b0;
      uart1_transmit_timer_select <= 1'b0;
    end else begin
      dbg_cmp_en                  <= clk_q[`CLK_DBG_BIT];
      uart0_rate_doubler          <= pwr_q[`PWR_DBL0_BIT];
      uart1_rate_doubler          <= pwr_q[`PWR_DBL1_BIT];
      uart1_receive_timer_select  <= pwr_q[`PWR_RX_SEL_BIT];
      uart1_transmit_timer_select <= pwr_q[`PWR_TX_SEL_BIT];
    end
  end

  // Helper for the restart check: clocks since reset release
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rel_cnt_q <= 8'h00;
    end else if (rel_cnt_q != 8'hFF) begin
      rel_cnt_q <= rel_cnt_q + 8'h01;
    end
  end

  sequence s_light_entry;
    (state_q == ST_RUN) && wr_pwr && sfr_req.wdata[`PWR_LIGHT_BIT]
      && !sfr_req.wdata[`PWR_DEEP_BIT] && !irq_req;
  endsequence

  sequence s_light_parked;
    (state_q == ST_LIGHT) ##1 (!core_clk_en && unit_clk_en && !wdt_clk_en);
  endsequence

  property p_light_clocks;
    @(posedge sys_clk) disable iff (!rst_b)
      s_light_entry |=> s_light_parked;
  endproperty
  a_light_clocks: assert property (p_light_clocks)
    else $error("light sleep clock enables wrong");

  property p_light_wake;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_q == ST_LIGHT) && irq_req && !wr_pwr
        |=> (state_q == ST_RUN) && !pwr_q[`PWR_LIGHT_BIT];
  endproperty
  a_light_wake: assert property (p_light_wake)
    else $error("interrupt did not end light sleep");

  property p_deep_stop;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_q == ST_DEEP) |=> osc_stop && !unit_clk_en && !core_clk_en
        && (state_q == ST_DEEP);
  endproperty
  a_deep_stop: assert property (p_deep_stop)
    else $error("deep sleep left clocks running");

  property p_deep_entry;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_q == ST_RUN) && wr_pwr && sfr_req.wdata[`PWR_DEEP_BIT]
        |=> ##1 osc_stop && !unit_clk_en;
  endproperty
  a_deep_entry: assert property (p_deep_entry)
    else $error("deep sleep not entered");

  property p_bus_park;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_q != ST_RUN) |=> !ext_bus.ale && ext_bus.fetch_strobe_n && ext_bus.rd_n
        && ext_bus.wr_n && (ext_bus.ad == 8'hFF) && (ext_bus.addr_hi == 8'hFF) && port_hold;
  endproperty
  a_bus_park: assert property (p_bus_park)
    else $error("bus not parked in sleep");

  property p_auto_restore;
    @(posedge sys_clk) disable iff (!rst_b)
      irq_req && clk_q[`CLK_AUTO_BIT] && !wr_clk && (state_q != ST_DEEP)
        |=> (clk_q[`CLK_DIV_MSB:`CLK_DIV_LSB] == 3'h0);
  endproperty
  a_auto_restore: assert property (p_auto_restore)
    else $error("auto restore did not clear divider");

  property p_cold_keep;
    @(posedge sys_clk) disable iff (!rst_b)
      !wr_pwr |=> $stable(pwr_q[`PWR_COLD_BIT]);
  endproperty
  a_cold_keep: assert property (p_cold_keep)
    else $error("cold-start flag changed without reset or write");

  property p_restart;
    @(posedge sys_clk) disable iff (!rst_b)
      $fell(hold_q) |-> (rel_cnt_q == 8'(RESTART_CLKS));
  endproperty
  a_restart: assert property (p_restart)
    else $error("core restart delay wrong");

  sequence s_half_rate;
    core_clk_en && (state_q == ST_RUN) && !hold_q
      && (clk_q[`CLK_DIV_MSB:`CLK_DIV_LSB] == 3'h1) && !wr_clk && !irq_req && !wr_pwr;
  endsequence

  property p_div_two;
    @(posedge sys_clk) disable iff (!rst_b)
      s_half_rate ##1 (!wr_clk && !irq_req && !wr_pwr) |-> !core_clk_en ##1 core_clk_en;
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("divide-by-two spacing wrong");

  property p_bit5_zero;
    @(posedge sys_clk) disable iff (!rst_b)
      wr_pwr |=> !pwr_q[`PWR_RSVD_BIT];
  endproperty
  a_bit5_zero: assert property (p_bit5_zero)
    else $error("reserved bit stored");
endmodule

// ===== verif/core_side_model.sv
// Behavioural stand-in for the processor core facing the block.
// Assumes the bench raises fire for one cycle per interrupt taken.
`timescale 1ns/1ps
module core_side_model (
  input  wire logic          sys_clk,  // Oscillator clock
  input  wire logic          rst_b,    // Supervisor reset, low
  input  wire logic          fire,     // Bench asks for an interrupt
  output logic               irq_req,  // Interrupt taken by the core
  output pmcc_pkg::ext_bus_s core_bus  // Live bus of the running core
);
  import pmcc_pkg::*;
  logic [7:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Bus moves every cycle so a parked output cannot match by chance
  assign core_bus = '{ale: cnt_q[0], fetch_strobe_n: cnt_q[1], rd_n: cnt_q[2],
                      wr_n: cnt_q[3], ad: cnt_q, ad_oe: cnt_q[4], addr_hi: ~cnt_q};
  assign irq_req  = fire;
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the power-mode and clock control block.
// Assumes the block and its core-side model share one 40 MHz clock.
`timescale 1ns/1ps
`include "pmcc_cfg.svh"
module tb_top;
  import pmcc_pkg::*;
  localparam int MC = 2;
  logic sys_clk, rst_b, cold_reset, fire, irq_req;
  logic [7:0] sfr_rdata;
  logic sfr_hit, core_clk_en, wdt_clk_en, unit_clk_en, osc_stop, port_hold, dbg_cmp_en;
  logic u0_dbl, u1_dbl, u1_rx, u1_tx;
  sfr_req_s sfr_req;
  ext_bus_s core_bus, ext_bus;
  int mismatches, n_checks, k;
  logic [11:0] divs [8] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h010, 12'h020, 12'h400,
                            12'h800};

  power_mode_clock_control #(.OSC_PER_MCYC(MC)) i_power_mode_clock_control (
    .sys_clk(sys_clk), .rst_b(rst_b), .cold_reset(cold_reset), .sfr_req(sfr_req),
    .irq_req(irq_req), .core_bus(core_bus), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .core_clk_en(core_clk_en), .wdt_clk_en(wdt_clk_en), .unit_clk_en(unit_clk_en),
    .osc_stop(osc_stop), .port_hold(port_hold), .dbg_cmp_en(dbg_cmp_en),
    .uart0_rate_doubler(u0_dbl), .uart1_rate_doubler(u1_dbl),
    .uart1_receive_timer_select(u1_rx), .uart1_transmit_timer_select(u1_tx),
    .ext_bus(ext_bus));
  core_side_model i_core_side_model (
    .sys_clk(sys_clk), .rst_b(rst_b), .fire(fire), .irq_req(irq_req), .core_bus(core_bus));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    cyc(1);
    sfr_req.wr = 1'b0;
    cyc(1);
  endtask

  // Waits a few cycles for the hit; a miss must stay silent and read zero
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    logic got;
    logic [7:0] d;
    got = 1'b0;
    d = 8'h00;
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    cyc(1);
    sfr_req.rd = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (sfr_hit === 1'b1 && !got) begin
        got = 1'b1;
        d = sfr_rdata;
      end
      cyc(1);
    end
    chk(got, hit);
    chk(d, exp);
  endtask

  // Cycles until the next core enable pulse; a lost pulse ends the run
  task automatic wait_pulse(input int bound, output int n);
    n = 0;
    while (core_clk_en !== 1'b1) begin
      cyc(1);
      n++;
      if (n > bound) begin
        mismatches++;
        conclude();
      end
    end
  endtask

  task automatic count_pulses(input int len, output int n);
    n = 0;
    repeat (len) begin
      cyc(1);
      if (core_clk_en !== 1'b0 || wdt_clk_en !== 1'b0) n++;
    end
  endtask

  task automatic do_reset(input logic cold, input int len);
    rst_b = 1'b0;
    cold_reset = cold;
    cyc(len);
    rst_b = 1'b1;
    cold_reset = 1'b0;
  endtask

  initial begin
    rst_b = 1'b0;
    cold_reset = 1'b1;
    fire = 1'b0;
    sfr_req = '0;
    mismatches = 0;
    n_checks = 0;
    cyc(1);
    do_reset(1'b1, 20);
    rd(8'h87, 8'h10, 1'b1);
    rd(8'hF9, 8'h10, 1'b1);
    chk(dbg_cmp_en, 1'b1);
    rd(8'h88, 8'h00, 1'b0);
    wr(8'h87, 8'hFC);
    rd(8'h87, 8'hDC, 1'b1);
    chk({u0_dbl, u1_dbl, u1_rx, u1_tx}, 4'hF);
    wr(8'h87, 8'h20);
    rd(8'h87, 8'h00, 1'b1);
    chk({u0_dbl, u1_dbl}, 2'b00);
    wr(8'h87, 8'h84);
    chk({u0_dbl, u1_dbl, u1_rx, u1_tx}, 4'h9);
    for (int c = 0; c < 8; c++) begin
      wr(8'hF9, 8'h10 | c[7:0]);
      wait_pulse(4200, k);
      chk(wdt_clk_en, 1'b1);
      cyc(1);
      wait_pulse(4200, k);
      chk(20'(k + 1), 20'(divs[c]));
      chk(unit_clk_en, 1'b1);
    end
    wr(8'hF9, 8'h0D);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    rd(8'hF9, 8'h08, 1'b1);
    wait_pulse(4, k);
    wr(8'hF9, 8'h00);
    chk(dbg_cmp_en, 1'b0);
    fire = 1'b1;
    wr(8'h87, 8'h01);
    fire = 1'b0;
    rd(8'h87, 8'h00, 1'b1);
    chk(port_hold, 1'b0);
    wr(8'h87, 8'h01);
    cyc(1);
    count_pulses(40, k);
    chk(20'(k), 0);
    chk({unit_clk_en, osc_stop, port_hold}, 3'b101);
    chk({ext_bus.ale, ext_bus.fetch_strobe_n, ext_bus.rd_n, ext_bus.wr_n,
         ext_bus.ad, ext_bus.addr_hi}, 20'h7_FFFF);
    chk(ext_bus.ad_oe, 1'b1);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    wait_pulse(4, k);
    rd(8'h87, 8'h00, 1'b1);
    chk(port_hold, 1'b0);
    chk(8'(ext_bus.ad + 8'h01), core_bus.ad);
    wr(8'h87, 8'h01);
    do_reset(1'b0, 2);
    wait_pulse(3 * MC + 4, k);
    chk(k >= 3 * MC, 1'b1);
    rd(8'h87, 8'h00, 1'b1);
    wr(8'h87, 8'h02);
    cyc(2);
    chk({osc_stop, unit_clk_en, port_hold}, 3'b101);
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    count_pulses(20, k);
    chk(20'(k), 0);
    chk({osc_stop, ext_bus.ale, ext_bus.ad}, 10'h2FF);
    do_reset(1'b1, 3);
    rd(8'h87, 8'h10, 1'b1);
    chk({osc_stop, unit_clk_en}, 2'b01);
    do_reset(1'b0, 2);
    rd(8'h87, 8'h10, 1'b1);
    conclude();
  end
endmodule
